//--- src/ira_regs.sv
// register bank with link-loss timer and two indirect access windows
// assumes host port, analog blocks and apb targets share clk
// Functional notes
// - drop link detect when timer expires
// - two-bit code picks one of four timeouts
// - analog select: off, video receiver, link transmitter
// - analog offset steps by one after access
// - read-not-write bit blocks analog value writes; host read or write gives direction
// - offset register addresses analog block register
// - value write goes to selected analog register
// - value read returns selected analog register
// - apb select: configuration data or die identifier
// - apb address steps by one after access
// - read-start launches apb read, clears when done
// - apb window works only while enabled
// - apb address and value low bytes exposed
`timescale 1ns/100ps
module ira_regs
	import ira_pkg::*;
#(
	parameter int LINK_CYC_00 = LINK_T00_CYC,
	parameter int LINK_CYC_01 = LINK_T01_CYC,
	parameter int LINK_CYC_10 = LINK_T10_CYC,
	parameter int LINK_CYC_11 = LINK_T11_CYC
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// host register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWr,
	input  wire logic       regRd,
	input  wire logic [7:0] regWrData,
	output logic [7:0]      regRdData,
	output logic            regRdValid,
	output logic            regBusy,
	// reverse channel
	input  wire logic       rxValid,
	output logic            linkDetect,
	// analog block access
	output logic            anaReq,
	output logic            anaWe,
	output logic [1:0]      anaBlock,
	output logic [7:0]      anaAddr,
	output logic [7:0]      anaWdata,
	input  wire logic [7:0] anaRdata,
	input  wire logic       anaAck,
	// apb pins
	output logic [7:0]      paddr,
	output logic [1:0]      psel,
	output logic            penable,
	output logic            pwrite,
	input  wire logic [7:0] prdata,
	input  wire logic       pready
);
	typedef enum logic {ANA_IDLE, ANA_WAIT} ira_ana_e;

	ira_apb_if apbIf ();

	logic [1:0]            linkSel;
	logic [LINK_CNT_W-1:0] linkCnt;
	logic [LINK_CNT_W-1:0] linkLimit;
	logic [2:0]            anaSel;
	logic                  anaStep;
	logic                  anaRnw;
	logic [7:0]            anaOffset;
	ira_ana_e              anaState;
	logic                  anaOk;
	logic                  anaDone;
	logic [1:0]            apbSel;
	logic                  apbStep;
	logic                  apbReadStart;
	logic                  apbEnable;
	logic [7:0]            apbAddrLow;
	logic [7:0]            apbValueLow;
	logic                  apbLaunch;
	logic                  hostWr;
	logic                  hostRd;
	logic [7:0]            next_rdData;

	assign hostWr  = regWr && !regBusy;
	assign hostRd  = regRd && !regBusy;
	assign regBusy = (anaState == ANA_WAIT);
	assign anaOk   = (anaSel == ANA_SEL_VIDEO) || (anaSel == ANA_SEL_LINK);
	assign anaDone = (anaState == ANA_WAIT) && anaAck;

	// link-loss timer
	always_comb
	begin
		unique case (linkSel)
			2'h0: linkLimit = LINK_CNT_W'(LINK_CYC_00);
			2'h1: linkLimit = LINK_CNT_W'(LINK_CYC_01);
			2'h2: linkLimit = LINK_CNT_W'(LINK_CYC_10);
			2'h3: linkLimit = LINK_CNT_W'(LINK_CYC_11);
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			linkSel <= 2'h0;
		else if (hostWr && regAddr == OFS_LINK_CTL)
			linkSel <= regWrData[LINK_SEL_LSB +: 2];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			linkCnt    <= '0;
			linkDetect <= 1'b0;
		end
		else if (rxValid)
		begin
			linkCnt    <= '0;
			linkDetect <= 1'b1;
		end
		else if (linkDetect)
		begin
			if (linkCnt >= linkLimit - LINK_CNT_W'(1))
			begin
				linkCnt    <= '0;
				linkDetect <= 1'b0;
			end
			else
				linkCnt <= linkCnt + LINK_CNT_W'(1);
		end
	end

	// analog window control and offset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			anaSel  <= ANA_SEL_OFF;
			anaStep <= 1'b0;
			anaRnw  <= 1'b0;
		end
		else if (hostWr && regAddr == OFS_ANA_CTL)
		begin
			anaSel  <= regWrData[ANA_SEL_LSB +: 3];
			anaStep <= regWrData[ANA_STEP_BIT];
			anaRnw  <= regWrData[ANA_RNW_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			anaOffset <= RESET_BYTE;
		else if (anaDone && anaStep)
			anaOffset <= anaOffset + ONE_BYTE;
		else if (hostWr && regAddr == OFS_ANA_OFS)
			anaOffset <= regWrData;
	end

	// analog access engine: request held until the block acknowledges
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			anaState <= ANA_IDLE;
			anaReq   <= 1'b0;
			anaWe    <= 1'b0;
			anaBlock <= 2'h0;
			anaAddr  <= RESET_BYTE;
			anaWdata <= RESET_BYTE;
		end
		else
		begin
			unique case (anaState)
				ANA_IDLE:
				begin
					if (anaOk && ((hostWr && !anaRnw) || hostRd)
						&& regAddr == OFS_ANA_VAL)
					begin
						anaState    <= ANA_WAIT;
						anaReq      <= 1'b1;
						anaWe       <= hostWr;
						anaAddr     <= anaOffset;
						anaWdata    <= regWrData;
						anaBlock[0] <= (anaSel == ANA_SEL_VIDEO);
						anaBlock[1] <= (anaSel == ANA_SEL_LINK);
					end
				end
				ANA_WAIT:
				begin
					if (anaAck)
					begin
						anaState <= ANA_IDLE;
						anaReq   <= 1'b0;
						anaWe    <= 1'b0;
					end
				end
			endcase
		end
	end

	// apb window
	assign apbLaunch = hostWr && regAddr == OFS_APB_PORT_CONTROL && regWrData[APB_READ_BIT]
		&& regWrData[APB_EN_BIT] && regWrData[APB_SEL_LSB+1] && !apbReadStart;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			apbSel    <= 2'h0;
			apbStep   <= 1'b0;
			apbEnable <= 1'b0;
		end
		else if (hostWr && regAddr == OFS_APB_PORT_CONTROL)
		begin
			apbSel    <= regWrData[APB_SEL_LSB +: 2];
			apbStep   <= regWrData[APB_STEP_BIT];
			apbEnable <= regWrData[APB_EN_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			apbReadStart <= 1'b0;
		else if (apbLaunch)
			apbReadStart <= 1'b1;
		else if (apbIf.done)
			apbReadStart <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			apbAddrLow <= RESET_BYTE;
		else if (apbIf.done && apbStep)
			apbAddrLow <= apbAddrLow + ONE_BYTE;
		else if (hostWr && regAddr == OFS_APB_ADDR)
			apbAddrLow <= regWrData;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			apbValueLow <= RESET_BYTE;
		else if (apbIf.done)
			apbValueLow <= apbIf.rdata;
		else if (hostWr && regAddr == OFS_APB_VALUE)
			apbValueLow <= regWrData;
	end

	assign apbIf.start = apbLaunch;
	assign apbIf.addr  = apbAddrLow;
	assign apbIf.sel   = regWrData[APB_SEL_LSB +: 2];

	ira_apb_master uApb (
		.clk     (clk),
		.srst    (srst),
		.req     (apbIf.engine),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.prdata  (prdata),
		.pready  (pready)
	);

	// read answer
	always_comb
	begin
		next_rdData = RESET_BYTE;
		unique case (regAddr)
			OFS_LINK_CTL:  next_rdData = {6'h00, linkSel};
			OFS_ANA_CTL:   next_rdData = {3'h0, anaSel, anaStep, anaRnw};
			OFS_ANA_OFS:   next_rdData = anaOffset;
			OFS_ANA_VAL:   next_rdData = RESET_BYTE;
			OFS_APB_PORT_CONTROL:   next_rdData = {3'h0, apbSel, apbStep, apbReadStart, apbEnable};
			OFS_APB_ADDR:  next_rdData = apbAddrLow;
			OFS_APB_VALUE: next_rdData = apbValueLow;
			default:       next_rdData = RESET_BYTE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			regRdData  <= RESET_BYTE;
			regRdValid <= 1'b0;
		end
		else if (anaDone && !anaWe)
		begin
			regRdData  <= anaRdata;
			regRdValid <= 1'b1;
		end
		else
		begin
			regRdValid <= hostRd && !(anaOk && regAddr == OFS_ANA_VAL);
			regRdData  <= next_rdData;
		end
	end

	// checks
	sequence anaWrReq_s;
		hostWr && regAddr == OFS_ANA_VAL && anaOk && !anaRnw && !regBusy;
	endsequence
	sequence anaIssued_s;
		anaReq && anaWe && anaWdata == $past(regWrData) && anaAddr == $past(anaOffset);
	endsequence

	link_drop_a: assert property (@(posedge clk) disable iff (srst)
		(linkDetect && !rxValid && linkCnt == linkLimit - LINK_CNT_W'(1)) |=> !linkDetect)
		else $error("link detect held past timeout");
	link_limit_a: assert property (@(posedge clk) disable iff (srst)
		(linkSel == 2'h1 && $fell(linkDetect)) |-> $past(linkCnt) == LINK_CNT_W'(LINK_CYC_01 - 1))
		else $error("wrong timeout for code 01");
	ana_write_a: assert property (@(posedge clk) disable iff (srst)
		anaWrReq_s |=> anaIssued_s)
		else $error("analog write not issued");
	ana_step_a: assert property (@(posedge clk) disable iff (srst)
		(anaDone && anaStep) |=> anaOffset == $past(anaOffset) + ONE_BYTE)
		else $error("analog offset not stepped");
	ana_read_a: assert property (@(posedge clk) disable iff (srst)
		(anaDone && !anaWe) |=> regRdValid && regRdData == $past(anaRdata))
		else $error("analog read data lost");
	ana_zero_a: assert property (@(posedge clk) disable iff (srst)
		(hostRd && regAddr == OFS_ANA_VAL && !anaOk) |=> regRdValid && regRdData == 8'h00 && !anaReq)
		else $error("reserved target read not zero");
	apb_clear_a: assert property (@(posedge clk) disable iff (srst)
		apbIf.done |=> !apbReadStart && apbValueLow == $past(apbIf.rdata))
		else $error("apb read not completed");
	apb_gate_a: assert property (@(posedge clk) disable iff (srst)
		$rose(penable) |-> $past(apbEnable, 2) || $past(apbLaunch, 2))
		else $error("apb access while disabled");
	apb_step_a: assert property (@(posedge clk) disable iff (srst)
		(apbIf.done && apbStep) |=> apbAddrLow == $past(apbAddrLow) + ONE_BYTE)
		else $error("apb address not stepped");
endmodule

//--- src/ira_pkg.sv
// shared constants of the indirect register access block
// assumes a 50 MHz clock and a byte-wide host register port
package ira_pkg;
	localparam int CLK_NS = 20;
	// register byte addresses
	localparam logic [7:0] OFS_LINK_CTL  = 8'h26;
	localparam logic [7:0] OFS_ANA_CTL   = 8'h40;
	localparam logic [7:0] OFS_ANA_OFS   = 8'h41;
	localparam logic [7:0] OFS_ANA_VAL   = 8'h42;
	localparam logic [7:0] OFS_APB_PORT_CONTROL   = 8'h48;
	localparam logic [7:0] OFS_APB_ADDR  = 8'h49;
	localparam logic [7:0] OFS_APB_VALUE = 8'h4B;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	// field positions
	localparam int LINK_SEL_LSB = 0;
	localparam int ANA_SEL_LSB  = 2;
	localparam int ANA_STEP_BIT = 1;
	localparam int ANA_RNW_BIT  = 0;
	localparam int APB_SEL_LSB  = 3;
	localparam int APB_STEP_BIT = 2;
	localparam int APB_READ_BIT = 1;
	localparam int APB_EN_BIT   = 0;
	// analog target codes
	localparam logic [2:0] ANA_SEL_OFF   = 3'h0;
	localparam logic [2:0] ANA_SEL_VIDEO = 3'h4;
	localparam logic [2:0] ANA_SEL_LINK  = 3'h5;
	// apb target codes
	localparam logic [1:0] APB_SEL_CFG = 2'h2;
	localparam logic [1:0] APB_SEL_DIE = 2'h3;
	// link-loss timeouts
	localparam int LINK_T00_NS = 325000;
	localparam int LINK_T01_NS = 162000;
	localparam int LINK_T10_NS = 650000;
	localparam int LINK_T11_NS = 1300000;
	localparam int LINK_T00_CYC = LINK_T00_NS / CLK_NS;
	localparam int LINK_T01_CYC = LINK_T01_NS / CLK_NS;
	localparam int LINK_T10_CYC = LINK_T10_NS / CLK_NS;
	localparam int LINK_T11_CYC = LINK_T11_NS / CLK_NS;
	localparam int LINK_CNT_W = 17;
	localparam logic [7:0] ONE_BYTE = 8'h01;
endpackage

//--- src/ira_apb_if.sv
// request and answer between the register bank and its apb engine
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface ira_apb_if;
	logic       start;
	logic [7:0] addr;
	logic [1:0] sel;
	logic       done;
	logic [7:0] rdata;
	modport ctrl (output start, output addr, output sel, input done, input rdata);
	modport engine (input start, input addr, input sel, output done, output rdata);
endinterface

//--- src/ira_apb_master.sv
// apb read engine for the indirect apb window
// assumes read-only apb targets on the same clock
`timescale 1ns/100ps
module ira_apb_master
	import ira_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// request side
	ira_apb_if.engine       req,
	// apb pins
	output logic [7:0]      paddr,
	output logic [1:0]      psel,
	output logic            penable,
	output logic            pwrite,
	input  wire logic [7:0] prdata,
	input  wire logic       pready
);
	typedef enum logic [1:0] {APB_IDLE, APB_SETUP, APB_ACCESS} ira_apb_e;
	ira_apb_e state;

	assign pwrite = 1'b0;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state   <= APB_IDLE;
			psel    <= 2'h0;
			penable <= 1'b0;
			paddr   <= RESET_BYTE;
		end
		else
		begin
			unique case (state)
				APB_IDLE:
				begin
					if (req.start)
					begin
						state   <= APB_SETUP;
						paddr   <= req.addr;
						// one select line per target
						psel[0] <= (req.sel == APB_SEL_CFG);
						psel[1] <= (req.sel == APB_SEL_DIE);
					end
				end
				APB_SETUP:
				begin
					state   <= APB_ACCESS;
					penable <= 1'b1;
				end
				APB_ACCESS:
				begin
					if (pready)
					begin
						state   <= APB_IDLE;
						psel    <= 2'h0;
						penable <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			req.done  <= 1'b0;
			req.rdata <= RESET_BYTE;
		end
		else
		begin
			req.done <= (state == APB_ACCESS) && pready;
			if ((state == APB_ACCESS) && pready)
				req.rdata <= prdata;
		end
	end
endmodule

//--- test/ira_far_model.sv
// far-side model: two analog register blocks and read-only apb targets
// assumes the bank's analog and apb pins on one clock; lag sets answer delay
`timescale 1ns/100ps
module ira_far_model
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// analog block side
	input  wire logic       anaReq,
	input  wire logic       anaWe,
	input  wire logic [1:0] anaBlock,
	input  wire logic [7:0] anaAddr,
	input  wire logic [7:0] anaWdata,
	output logic [7:0]      anaRdata,
	output logic            anaAck,
	// apb target side
	input  wire logic [7:0] paddr,
	input  wire logic [1:0] psel,
	input  wire logic       penable,
	output logic [7:0]      prdata,
	output logic            pready,
	// answer delay in cycles
	input  wire logic [2:0] lag
);
	logic [7:0] mem [2][256];
	logic [2:0] waitCnt;
	// idle data lines toggle so stale values never pass for answers
	always_ff @(posedge clk)
	begin
		anaAck   <= 1'b0;
		pready   <= 1'b0;
		anaRdata <= ~anaRdata;
		prdata   <= ~prdata;
		if (srst)
		begin
			waitCnt  <= 3'h0;
			anaRdata <= 8'h00;
			prdata   <= 8'h00;
		end
		else if ((anaReq && !anaAck) || (psel != 2'h0 && penable && !pready))
		begin
			waitCnt <= waitCnt + 3'h1;
			if (waitCnt >= lag)
			begin
				waitCnt <= 3'h0;
				if (anaReq)
				begin
					anaAck   <= 1'b1;
					anaRdata <= mem[anaBlock[1]][anaAddr];
					if (anaWe)
						mem[anaBlock[1]][anaAddr] <= anaWdata;
				end
				else
				begin
					pready <= 1'b1;
					prdata <= psel[1] ? (paddr ^ 8'hC3) : (paddr + 8'h11);
				end
			end
		end
	end
endmodule

//--- test/test_indirect_register_access.sv
// self-checking bench of the indirect register access bank
// assumes ira_far_model stands for the analog blocks and apb targets
`timescale 1ns/100ps
module test_indirect_register_access;
	import ira_pkg::*;
	logic       clk;
	logic       srst;
	logic [7:0] regAddr;
	logic       regWr;
	logic       regRd;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic       regRdValid;
	logic       regBusy;
	logic       rxValid;
	logic       linkDetect;
	logic       anaReq;
	logic       anaWe;
	logic [1:0] anaBlock;
	logic [7:0] anaAddr;
	logic [7:0] anaWdata;
	logic [7:0] anaRdata;
	logic       anaAck;
	logic [7:0] paddr;
	logic [1:0] psel;
	logic       penable;
	logic       pwrite;
	logic [7:0] prdata;
	logic       pready;
	logic [2:0] lag;
	int         errCount = 0;
	int         checksDone = 0;
	int         seed;
	int         n;
	logic [7:0] v;
	logic [7:0] a;
	logic [2:0] sel;
	logic [7:0] dat [2][3];
	int         lim [4] = '{40, 20, 80, 160};
	logic [7:0] ofs [8] = '{OFS_LINK_CTL, OFS_ANA_CTL, OFS_ANA_OFS, OFS_ANA_VAL,
		OFS_APB_PORT_CONTROL, OFS_APB_ADDR, OFS_APB_VALUE, 8'h4A};
	logic [2:0] badSel [4] = '{ANA_SEL_OFF, 3'h1, 3'h6, 3'h7};
	ira_regs #(.LINK_CYC_00(40), .LINK_CYC_01(20), .LINK_CYC_10(80), .LINK_CYC_11(160)) uut
	(
		.clk(clk), .srst(srst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
		.regBusy(regBusy), .rxValid(rxValid), .linkDetect(linkDetect), .anaReq(anaReq),
		.anaWe(anaWe), .anaBlock(anaBlock), .anaAddr(anaAddr), .anaWdata(anaWdata),
		.anaRdata(anaRdata), .anaAck(anaAck), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready)
	);
	ira_far_model far
	(
		.clk(clk), .srst(srst), .anaReq(anaReq), .anaWe(anaWe), .anaBlock(anaBlock),
		.anaAddr(anaAddr), .anaWdata(anaWdata), .anaRdata(anaRdata), .anaAck(anaAck),
		.paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata),
		.pready(pready), .lag(lag)
	);
	function automatic logic [7:0] apbExp(input logic [1:0] s, input logic [7:0] ad);
		return (s == APB_SEL_DIE) ? (ad ^ 8'hC3) : (ad + 8'h11);
	endfunction
	task automatic conclude();
		$display("checks %0d errors %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			errCount++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one cycle gap first, then wait out a pending analog access
	task automatic idle();
		int k;
		k = 0;
		@(posedge clk);
		#1;
		while (regBusy && k < 100)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		idle();
		regAddr = ad;
		regWrData = d;
		regWr = 1'b1;
		@(posedge clk);
		#1;
		regWr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		int k;
		k = 0;
		idle();
		regAddr = ad;
		regRd = 1'b1;
		@(posedge clk);
		#1;
		regRd = 1'b0;
		while (!regRdValid && k < 100)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		d = regRdData;
	endtask
	task automatic rc(input logic [7:0] ad, input logic [7:0] exp);
		logic [7:0] d;
		rd(ad, d);
		chk(d, exp);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #(CLK_NS / 2) clk = ~clk;
	end
	initial
	begin
		#(CLK_NS * 20000);
		errCount++;
		conclude();
	end
	initial
	begin
		seed = 32'h0ECE512C;
		srst = 1'b1;
		regAddr = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		regWrData = 8'h00;
		rxValid = 1'b0;
		lag = 3'h0;
		repeat (8) @(posedge clk);
		#1;
		srst = 1'b0;
		foreach (ofs[i]) rc(ofs[i], RESET_BYTE);
		wr(8'h4A, 8'hFF);
		rc(8'h4A, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			wr(OFS_LINK_CTL, 8'(c));
			rxValid = 1'b1;
			@(posedge clk);
			#1;
			rxValid = 1'b0;
			chk({7'h0, linkDetect}, 8'h01);
			n = 0;
			while (linkDetect && n < 400)
			begin
				@(posedge clk);
				#1;
				n++;
			end
			chk({7'h0, n >= lim[c] - 2 && n <= lim[c] + 1}, 8'h01);
		end
		// same offset in both blocks, wrapping past the top byte
		for (int t = 0; t < 2; t++)
		begin
			sel = t ? ANA_SEL_LINK : ANA_SEL_VIDEO;
			wr(OFS_ANA_CTL, {3'h0, sel, 2'b10});
			rc(OFS_ANA_CTL, {3'h0, sel, 2'b10});
			wr(OFS_ANA_OFS, 8'hFE);
			for (int k = 0; k < 3; k++)
			begin
				dat[t][k] = 8'($random(seed));
				lag = 3'($random(seed));
				wr(OFS_ANA_VAL, dat[t][k]);
			end
			rc(OFS_ANA_OFS, 8'h01);
		end
		for (int t = 0; t < 2; t++)
		begin
			sel = t ? ANA_SEL_LINK : ANA_SEL_VIDEO;
			wr(OFS_ANA_CTL, {3'h0, sel, 2'b10});
			wr(OFS_ANA_OFS, 8'hFE);
			for (int k = 0; k < 3; k++) rc(OFS_ANA_VAL, dat[t][k]);
		end
		wr(OFS_ANA_CTL, {3'h0, ANA_SEL_VIDEO, 2'b01});
		wr(OFS_ANA_OFS, 8'hFE);
		wr(OFS_ANA_VAL, ~dat[0][0]);
		rc(OFS_ANA_VAL, dat[0][0]);
		rc(OFS_ANA_OFS, 8'hFE);
		foreach (badSel[i])
		begin
			wr(OFS_ANA_CTL, {3'h0, badSel[i], 2'b00});
			wr(OFS_ANA_VAL, 8'h77);
			rc(OFS_ANA_VAL, 8'h00);
		end
		wr(OFS_ANA_CTL, {3'h0, ANA_SEL_VIDEO, 2'b00});
		rc(OFS_ANA_VAL, dat[0][0]);
		for (int s = 2; s < 4; s++)
		begin
			a = (s == 2) ? 8'hFF : 8'($random(seed));
			lag = 3'($random(seed));
			wr(OFS_APB_ADDR, a);
			wr(OFS_APB_PORT_CONTROL, {3'h0, 2'(s), 3'b111});
			v = 8'h02;
			n = 0;
			while (v[1] && n < 50)
			begin
				rd(OFS_APB_PORT_CONTROL, v);
				n++;
			end
			chk(v, {3'h0, 2'(s), 3'b101});
			chk({7'h0, pwrite}, 8'h00);
			rc(OFS_APB_VALUE, apbExp(2'(s), a));
			rc(OFS_APB_ADDR, a + 8'h01);
		end
		wr(OFS_APB_PORT_CONTROL, {3'h0, APB_SEL_CFG, 3'b010});
		rc(OFS_APB_PORT_CONTROL, {3'h0, APB_SEL_CFG, 3'b000});
		wr(OFS_APB_PORT_CONTROL, 8'h0B);
		rc(OFS_APB_PORT_CONTROL, 8'h09);
		rc(OFS_APB_VALUE, apbExp(APB_SEL_DIE, a));
		conclude();
	end
endmodule
